// ==== core/efr_dev.sv ====
// EEPROM end: feature register and identification page read path
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Features reached only by random reads
// - Read needs an address loaded beforehand
// - Select, address bytes, repeated start, read
// - Type identifier read never advances counter
// - Type identifier refused during write cycle
// - Configurable address read never advances counter
// - Configurable address refused during write cycle
// - Acknowledge select only when b3 matches
// - Protection register read never advances counter
// - Protection register refused during write cycle
// - Controller ends stream with no-ack, stop
// - Sample controller acknowledge in ninth slot
// - Page counter increments, wraps FFh to 00h
// - Missing acknowledge releases data, goes standby
// - Probe data acknowledged only when unlocked
// - Controller follows probe with start, stop
// - Start discards any partial command
// - Stop returns device to standby
// - Read select repeats write select bits
// - Factory values: FFh page, 00h registers
// - Write cycle: no acknowledge to anything
module efr_dev #(
  parameter efr_pkg::efr_byte_t TYPE_ID_VALUE = 8'h_5A  // Arbitrary identity value
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  efr_link_if.dev                 link,
  input  wire logic               write_busy,
  input  wire logic               page_locked,
  input  wire logic               cfg_we,
  input  wire logic               cfg_sel,
  input  wire efr_pkg::efr_byte_t cfg_data,
  input  wire logic               idp_we,
  input  wire efr_pkg::efr_byte_t idp_addr,
  input  wire efr_pkg::efr_byte_t idp_data,
  output efr_pkg::efr_byte_t      cadr_value,
  output efr_pkg::efr_byte_t      prot_value,
  output logic                    cmd_active
);
  import efr_pkg::*;

  typedef enum logic [6:0] {
    SQ_IDLE = 7'b000_0001,
    SQ_RX   = 7'b000_0010,
    SQ_ACKW = 7'b000_0100,
    SQ_ACK  = 7'b000_1000,
    SQ_TX   = 7'b001_0000,
    SQ_MACK = 7'b010_0000,
    SQ_LOAD = 7'b100_0000
  } efr_dev_state_e;

  efr_dev_state_e state_q, state_d;
  logic [1:0]     scl_sync_q;
  logic [1:0]     sda_sync_q;
  logic           scl_prev_q;
  logic           sda_prev_q;
  logic [2:0]     cnt_q, cnt_d;
  efr_byte_t      shift_q, shift_d;
  logic [1:0]     phase_q, phase_d;
  logic           rd_q, rd_d;
  logic [1:0]     tgt_q, tgt_d;
  efr_byte_t      offs_q, offs_d;
  logic           valid_q, valid_d;
  logic [6:0]     sel7_q, sel7_d;
  logic           drive_q, drive_d;
  efr_byte_t      cadr_q;
  efr_byte_t      prot_q;
  efr_byte_t      idp_mem [256];
  logic [255:0]   idp_written_q;

  // Two-stage synchronisers; edge detectors look only at the second stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Bus events
  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Select decode: family, chip-select bit against the stored one
  wire chip_select_config_bit = cadr_q[CFG_CS_POS];
  wire sel_match = (shift_q[7:4] == SEL_FEATURE)
                 & (shift_q[SEL_CS_POS] == chip_select_config_bit);
  // A read select only counts after a dummy write in this transaction
  wire rd_sel_ok = valid_q & (shift_q[7:1] == sel7_q);
  wire sel_ack   = sel_match & (~shift_q[0] | rd_sel_ok);
  // Lock probe: acknowledge the data byte only on an unlocked page
  wire probe_ack = (tgt_q == TGT_IDP) & ~page_locked;

  // Acknowledge decision per byte phase
  logic ack_ok;
  always_comb begin
    case (phase_q)
      PH_SEL:  ack_ok = sel_ack;
      PH_HI:   ack_ok = (shift_q[7:2] == 6'h_00);
      PH_LO:   ack_ok = 1'b1;
      default: ack_ok = probe_ack;
    endcase
  end

  // Outgoing byte; registers ignore the counter, page uses it
  efr_byte_t idp_rd;
  efr_byte_t tx_byte;
  assign idp_rd = idp_written_q[offs_q] ? idp_mem[offs_q] : IDP_ERASED;
  always_comb begin
    case (tgt_q)
      TGT_IDP: tx_byte = idp_rd;
      TGT_TYPE: tx_byte = TYPE_ID_VALUE;
      TGT_CADR: tx_byte = cadr_q;
      default:  tx_byte = prot_q;
    endcase
  end

  // Command sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    phase_d = phase_q;
    rd_d    = rd_q;
    tgt_d   = tgt_q;
    offs_d  = offs_q;
    valid_d = valid_q;
    sel7_d  = sel7_q;
    drive_d = drive_q;
    if (write_busy) begin
      // Off the bus for the whole write cycle
      state_d = SQ_IDLE;
      drive_d = 1'b0;
    end else if (stop_ev) begin
      state_d = SQ_IDLE;
      drive_d = 1'b0;
      valid_d = 1'b0;
    end else if (start_ev) begin
      state_d = SQ_RX;
      cnt_d   = 3'd0;
      phase_d = PH_SEL;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        SQ_IDLE: begin
          drive_d = 1'b0;
        end
        SQ_RX: if (scl_rise) begin
          shift_d = {shift_q[6:0], sda_s};
          cnt_d   = 3'(cnt_q + 3'd1);
          if (cnt_q == 3'd7) begin
            state_d = SQ_ACKW;
          end
        end
        SQ_ACKW: if (scl_fall) begin
          drive_d = ack_ok;
          state_d = ack_ok ? SQ_ACK : SQ_IDLE;
          if (phase_q == PH_SEL) begin
            rd_d = shift_q[0];
            if (!shift_q[0]) begin
              sel7_d  = shift_q[7:1];
              valid_d = 1'b0;
            end
          end
          if (phase_q == PH_HI) begin
            tgt_d = shift_q[1:0];
          end
          if (phase_q == PH_LO) begin
            offs_d  = shift_q;
            valid_d = 1'b1;
          end
        end
        SQ_ACK, SQ_LOAD: if (scl_fall) begin
          cnt_d = 3'd0;
          if (rd_q) begin
            shift_d = tx_byte;
            drive_d = ~tx_byte[7];
            state_d = SQ_TX;
          end else if (phase_q == PH_DATA) begin
            // Probe never executes; wait for start or stop
            drive_d = 1'b0;
            state_d = SQ_IDLE;
          end else begin
            drive_d = 1'b0;
            phase_d = 2'(phase_q + 2'd1);
            state_d = SQ_RX;
          end
        end
        SQ_TX: if (scl_fall) begin
          if (cnt_q == 3'd7) begin
            drive_d = 1'b0;
            state_d = SQ_MACK;
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            drive_d = ~shift_q[6];
            cnt_d   = 3'(cnt_q + 3'd1);
          end
        end
        SQ_MACK: if (scl_rise) begin
          if (tgt_q == TGT_IDP) begin
            offs_d = 8'(offs_q + 8'd1);
          end
          // Registers keep the counter: the same byte repeats
          state_d = sda_s ? SQ_IDLE : SQ_LOAD;
        end
        default: begin
          state_d = SQ_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SQ_IDLE;
      cnt_q   <= 3'd0;
      shift_q <= 8'h_00;
      phase_q <= PH_SEL;
      rd_q    <= 1'b0;
      tgt_q   <= TGT_IDP;
      offs_q  <= 8'h_00;
      valid_q <= 1'b0;
      sel7_q  <= 7'h_00;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      phase_q <= phase_d;
      rd_q    <= rd_d;
      tgt_q   <= tgt_d;
      offs_q  <= offs_d;
      valid_q <= valid_d;
      sel7_q  <= sel7_d;
      drive_q <= drive_d;
    end
  end

  // Configuration registers, loaded by the write path outside this block
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cadr_q <= CADR_RESET;
      prot_q <= PROT_RESET;
    end else if (cfg_we) begin
      if (cfg_sel) begin
        prot_q <= cfg_data;
      end else begin
        cadr_q <= cfg_data;
      end
    end
  end

  // Page cells never written read as erased, so no memory reset is needed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idp_written_q <= '0;
    end else if (idp_we) begin
      idp_written_q[idp_addr] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (idp_we) begin
      idp_mem[idp_addr] <= idp_data;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_b = ~drive_q;
  assign cadr_value        = cadr_q;
  assign prot_value        = prot_q;
  assign cmd_active        = (state_q != SQ_IDLE);
endmodule
`default_nettype wire

// ==== core/efr_pkg.sv ====
// Shared constants and types for the EEPROM feature read path
package efr_pkg;
  typedef logic [7:0]  efr_byte_t;
  typedef logic [31:0] efr_word_t;
  // Select code: family nibble, chip-select bit b3, direction bit b0
  localparam logic [3:0] SEL_FEATURE   = 4'h_B;
  localparam int         SEL_CS_POS    = 3;
  localparam int         CFG_CS_POS    = 1;
  // Target chosen by the first address byte
  localparam logic [1:0] TGT_IDP       = 2'h_0;
  localparam logic [1:0] TGT_TYPE      = 2'h_1;
  localparam logic [1:0] TGT_CADR      = 2'h_2;
  localparam logic [1:0] TGT_PROT      = 2'h_3;
  // Byte phases of a write-direction command
  localparam logic [1:0] PH_SEL        = 2'h_0;
  localparam logic [1:0] PH_HI         = 2'h_1;
  localparam logic [1:0] PH_LO         = 2'h_2;
  localparam logic [1:0] PH_DATA       = 2'h_3;
  // Factory contents
  localparam efr_byte_t  CADR_RESET    = 8'h_00;
  localparam efr_byte_t  PROT_RESET    = 8'h_00;
  localparam efr_byte_t  IDP_ERASED    = 8'h_FF;
  localparam efr_byte_t  PROBE_DATA    = 8'h_00;
  // Controller register map (byte addresses)
  localparam logic [7:0] OFS_CTRL      = 8'h_00;
  localparam logic [7:0] OFS_ADDR      = 8'h_04;
  localparam logic [7:0] OFS_COUNT     = 8'h_08;
  localparam logic [7:0] OFS_STATUS    = 8'h_0C;
  localparam int         CTRL_GO_POS   = 8;
  localparam int         CTRL_CS_POS   = 2;
  localparam int         STAT_BUSY_POS = 0;
  localparam int         STAT_DONE_POS = 1;
  localparam int         STAT_ACK_POS  = 2;
  // Controller command kinds
  localparam logic [1:0] KIND_READ     = 2'h_0;
  localparam logic [1:0] KIND_LOCK     = 2'h_1;
  localparam logic [1:0] KIND_PROBE    = 2'h_2;
  // Bus clock timing
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SCL_PERIOD_NS = 1000;
  localparam int         QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                         / (4 * CLK_PERIOD_NS);
endpackage

// ==== core/efr_link_if.sv ====
// Two-wire link between the bus controller and the EEPROM feature end
`timescale 1ns/10ps
`default_nettype none
interface efr_link_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_b;
  logic ctl_sda_o;
  logic ctl_sda_oe_b;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic scl;
  logic sda;
  // Open-drain wires with pull-up: a low enable drives the pin
  assign scl = ctl_scl_oe_b | ctl_scl_o;
  assign sda = (ctl_sda_oe_b | ctl_sda_o) & (dev_sda_oe_b | dev_sda_o);
  modport ctl (output ctl_scl_o, output ctl_scl_oe_b, output ctl_sda_o,
               output ctl_sda_oe_b, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe_b, input scl, input sda);
endinterface
`default_nettype wire

// ==== core/efr_ctl.sv ====
// Bus controller end: APB-driven feature reads and probes
`timescale 1ns/10ps
`default_nettype none
module efr_ctl (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire efr_pkg::efr_word_t pwdata,
  output efr_pkg::efr_word_t      prdata,
  output logic                    pready,
  output logic                    pslverr,
  efr_link_if.ctl                 link
);
  import efr_pkg::*;

  typedef enum logic [4:0] {
    OP_START = 5'b0_0001,
    OP_STOP  = 5'b0_0010,
    OP_WR    = 5'b0_0100,
    OP_RD    = 5'b0_1000,
    OP_END   = 5'b1_0000
  } efr_op_e;

  logic [1:0]  kind_q;
  logic        cs_q;
  logic [15:0] addr_q;
  efr_byte_t   count_q;
  logic        busy_q;
  logic        done_q;
  logic        ack_q;
  efr_byte_t   rx_q;
  efr_byte_t   shift_q;
  efr_byte_t   left_q;
  logic [3:0]  step_q;
  logic [1:0]  qtr_q;
  logic [3:0]  bit_q;
  logic [7:0]  div_q;
  logic [1:0]  sda_sync_q;
  logic        scl_q;
  logic        sda_q;
  efr_op_e     op;
  efr_byte_t   wbyte;

  // Step table of each command kind
  always_comb begin
    op    = OP_END;
    wbyte = {SEL_FEATURE, cs_q, 3'b000};
    case (kind_q)
      KIND_READ: begin
        case (step_q)
          4'd0, 4'd4: op = OP_START;
          4'd1:       op = OP_WR;
          4'd2: begin op = OP_WR; wbyte = addr_q[15:8]; end
          4'd3: begin op = OP_WR; wbyte = addr_q[7:0]; end
          4'd5: begin op = OP_WR; wbyte = {SEL_FEATURE, cs_q, 3'b001}; end
          4'd6:       op = OP_RD;
          4'd7:       op = OP_STOP;
          default:    op = OP_END;
        endcase
      end
      KIND_LOCK: begin
        case (step_q)
          4'd0, 4'd5: op = OP_START;
          4'd1:       op = OP_WR;
          4'd2: begin op = OP_WR; wbyte = addr_q[15:8]; end
          4'd3: begin op = OP_WR; wbyte = addr_q[7:0]; end
          4'd4: begin op = OP_WR; wbyte = PROBE_DATA; end
          4'd6:       op = OP_STOP;
          default:    op = OP_END;
        endcase
      end
      default: begin
        case (step_q)
          4'd0:    op = OP_START;
          4'd1:    op = OP_WR;
          4'd2:    op = OP_STOP;
          default: op = OP_END;
        endcase
      end
    endcase
  end

  // Pin levels per quarter of a bit slot
  wire mid_q   = (qtr_q == 2'd1) | (qtr_q == 2'd2);
  wire last_rd = (left_q <= 8'd1);
  logic scl_hi;
  logic sda_hi;
  always_comb begin
    scl_hi = 1'b1;
    sda_hi = 1'b1;
    if (busy_q) begin
      case (op)
        OP_START: begin scl_hi = mid_q; sda_hi = ~qtr_q[1]; end
        OP_STOP:  begin scl_hi = (qtr_q != 2'd0); sda_hi = qtr_q[1]; end
        OP_WR:    begin scl_hi = mid_q; sda_hi = bit_q[3] | wbyte[~bit_q[2:0]]; end
        OP_RD:    begin scl_hi = mid_q; sda_hi = ~bit_q[3] | last_rd; end
        default:  begin scl_hi = 1'b1; sda_hi = 1'b1; end
      endcase
    end
  end

  // APB decode
  wire tick    = (div_q == 8'(QTR_CYC - 1));
  wire wr_acc  = psel & penable & pwrite;
  wire hit     = (paddr == OFS_CTRL) | (paddr == OFS_ADDR)
               | (paddr == OFS_COUNT) | (paddr == OFS_STATUS);
  wire go      = wr_acc & (paddr == OFS_CTRL) & pwdata[CTRL_GO_POS] & ~busy_q;
  wire end_bit = busy_q & tick & (qtr_q == 2'd3);
  wire smp     = busy_q & tick & (qtr_q == 2'd2);
  efr_word_t rd_mux;
  assign rd_mux = (paddr == OFS_CTRL)   ? {29'd0, cs_q, kind_q} :
                  (paddr == OFS_ADDR)   ? {16'd0, addr_q} :
                  (paddr == OFS_COUNT)  ? {24'd0, count_q} :
                  (paddr == OFS_STATUS) ? {16'd0, rx_q, 5'd0, ack_q, done_q, busy_q} :
                  32'h_0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Software registers and read data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      kind_q  <= KIND_READ;
      cs_q    <= 1'b0;
      addr_q  <= 16'h_0000;
      count_q <= 8'h_01;
      prdata  <= 32'h_0000_0000;
    end else begin
      if (psel & ~penable) prdata <= rd_mux;
      if (wr_acc & (paddr == OFS_CTRL) & ~busy_q) begin
        kind_q <= pwdata[1:0];
        cs_q   <= pwdata[CTRL_CS_POS];
      end
      if (wr_acc & (paddr == OFS_ADDR)) addr_q <= pwdata[15:0];
      if (wr_acc & (paddr == OFS_COUNT)) count_q <= pwdata[7:0];
    end
  end

  // Bit engine: quarter-period divider, sampling, step advance
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q  <= 1'b0;
      rx_q   <= 8'h_00;
      shift_q <= 8'h_00;
      left_q <= 8'h_00;
      step_q <= 4'd0;
      qtr_q  <= 2'd0;
      bit_q  <= 4'd0;
      div_q  <= 8'd0;
    end else if (go) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      left_q <= count_q;
      step_q <= 4'd0;
      qtr_q  <= 2'd0;
      bit_q  <= 4'd0;
      div_q  <= 8'd0;
    end else if (busy_q) begin
      div_q <= tick ? 8'd0 : 8'(div_q + 8'd1);
      if (tick) qtr_q <= 2'(qtr_q + 2'd1);
      if (op == OP_END) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      if (smp & (op == OP_WR) & bit_q[3]) ack_q <= ~sda_sync_q[1];
      if (smp & (op == OP_RD) & ~bit_q[3]) shift_q <= {shift_q[6:0], sda_sync_q[1]};
      if (end_bit) begin
        if ((op == OP_START) | (op == OP_STOP)) begin
          step_q <= 4'(step_q + 4'd1);
        end else if (~bit_q[3]) begin
          bit_q <= 4'(bit_q + 4'd1);
        end else begin
          bit_q <= 4'd0;
          if (op == OP_RD) rx_q <= shift_q;
          if ((op == OP_RD) & ~last_rd) begin
            left_q <= 8'(left_q - 8'd1);
          end else if ((op == OP_WR) & ~ack_q & (kind_q == KIND_READ)) begin
            step_q <= 4'd7;
          end else begin
            step_q <= 4'(step_q + 4'd1);
          end
        end
      end
    end
  end

  // Data pin synchroniser and registered pin drive
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sda_sync_q <= 2'b11;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_q      <= scl_hi;
      sda_q      <= sda_hi;
    end
  end

  assign link.ctl_scl_o    = 1'b0;
  assign link.ctl_scl_oe_b = scl_q;
  assign link.ctl_sda_o    = 1'b0;
  assign link.ctl_sda_oe_b = sda_q;
endmodule
`default_nettype wire

// ==== sim/efr_link_properties.sv ====
// Framing and drive-timing checks on the two-wire feature link
`timescale 1ns/10ps
`default_nettype none
module efr_link_properties (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_b
);
  logic       scl_q, sda_q, first_q, wsel_q, rd_q, nack_q, idle_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [6:0] wb_q;
  // Start, stop and ninth-slot decode from sampled wires
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w  = scl & scl_q & ~sda_q & sda;
  wire ack_w   = scl & ~scl_q & (bit_q == 4'h_8);
  wire wack_w  = first_q & ~sda & ~sh_q[0];
  // Frame tracker; the rise inside a start or stop also counts, hence the <= 1 below
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {scl_q, sda_q, idle_q} <= 3'h_7;
      {first_q, wsel_q, rd_q, nack_q} <= 4'h_0;
      bit_q <= 4'h_0;
      sh_q  <= 8'h_00;
      wb_q  <= 7'h_00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w || stop_w) begin
        {bit_q, rd_q, nack_q} <= 6'h_00;
        first_q <= start_w;
        idle_q  <= stop_w;
        wsel_q  <= wsel_q & start_w;
      end else if (ack_w) begin
        bit_q   <= 4'h_0;
        first_q <= 1'b0;
        wsel_q  <= wsel_q | wack_w;
        wb_q    <= wack_w ? sh_q[7:1] : wb_q;
        rd_q    <= rd_q | (first_q & ~sda & sh_q[0]);
        nack_q  <= rd_q & sda;
      end else if (scl && !scl_q) begin
        bit_q <= bit_q + 4'h_1;
        sh_q  <= {sh_q[6:0], sda};
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Read select repeating an acknowledged write select
  sequence s_read_sel;
    ack_w && first_q && sh_q[0] && wsel_q && (sh_q[7:1] == wb_q);
  endsequence
  a_dev_hold_high: assert property (scl && scl_q |-> $stable(dev_sda_oe_b))
    else $error("device drive moved while clock high");
  a_dev_after_fall: assert property ($changed(dev_sda_oe_b) |-> !scl &&
    ($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
    else $error("device drive moved away from a clock fall");
  a_start_release: assert property (start_w |=> dev_sda_oe_b [*8])
    else $error("device drives right after a start");
  a_stop_standby: assert property (idle_q |-> dev_sda_oe_b)
    else $error("device drives after a stop");
  a_nack_release: assert property (nack_q |-> dev_sda_oe_b)
    else $error("device drives after a missing acknowledge");
  a_read_sel_ack: assert property (s_read_sel |-> !sda)
    else $error("repeated read select not acknowledged");
  a_read_ack_free: assert property (ack_w && rd_q |-> dev_sda_oe_b)
    else $error("device drives in the controller acknowledge slot");
  a_frame_whole: assert property (start_w || stop_w |-> bit_q <= 4'h_1)
    else $error("start or stop inside a byte");
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench: APB-driven controller facing the feature end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import efr_pkg::*;
  localparam efr_byte_t TYPE_ID_V = 8'h_3C;  // Arbitrary identity value
  logic        clk_sys, rst_b, psel, penable, pwrite, chk_en, pready, pslverr;
  logic        write_busy, page_locked, cfg_we, cfg_sel, idp_we, cs_cur;
  logic [7:0]  paddr;
  efr_byte_t   cfg_data, idp_addr, idp_data, pg0, pgf, cadr, prot;
  efr_word_t   pwdata, prdata, rword;
  logic [32:0] exp_m[$], exp_v[$], obs_m, obs_v;
  int          miscompares = 0;
  int          total_checks = 0;
  efr_link_if link ();
  efr_ctl efr_ctl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  efr_dev #(.TYPE_ID_VALUE(TYPE_ID_V)) efr_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .link(link),
    .write_busy(write_busy), .page_locked(page_locked), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .idp_we(idp_we), .idp_addr(idp_addr), .idp_data(idp_data),
    .cadr_value(), .prot_value(), .cmd_active());
  efr_link_properties efr_link_properties_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .scl(link.scl), .sda(link.sda), .dev_sda_oe_b(link.dev_sda_oe_b));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Result watcher: each flagged read completion takes the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && chk_en === 1'b1) begin
      total_checks++;
      obs_m = exp_m.pop_front();
      obs_v = exp_v.pop_front();
      if (({pslverr, prdata} & obs_m) !== obs_v) begin
        miscompares++;
        $display("BAD t=%0t exp=%h got=%h", $time, obs_v, {pslverr, prdata} & obs_m);
      end
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    tally_and_finish();
  endtask
  // APB master; the request stands until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input efr_word_t d, input logic c);
    int n;
    @(posedge clk_sys);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    chk_en  <= c;
    psel    <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rword = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk_en  <= 1'b0;
    if (n >= 64) timeout();
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [32:0] m, input logic [32:0] v);
    exp_m.push_back(m);
    exp_v.push_back(v);
    xfer(a, 1'b1 == 1'b0, 32'h0000_0000, 1'b1);
  endtask
  // One controller command, polled to completion with a bounded wait
  task automatic run(input logic [1:0] kind, input logic [7:0] hi, input logic [7:0] lo,
                     input logic [7:0] cnt);
    int n;
    xfer(OFS_ADDR, 1'b1, {16'h0000, hi, lo}, 1'b0);
    xfer(OFS_COUNT, 1'b1, {24'h00_0000, cnt}, 1'b0);
    xfer(OFS_CTRL, 1'b1, (32'h0000_0001 << CTRL_GO_POS) | (32'(cs_cur) << CTRL_CS_POS)
         | 32'(kind), 1'b0);
    n = 0;
    do begin
      xfer(OFS_STATUS, 1'b0, 32'h0000_0000, 1'b0);
      n++;
    end while ((rword[STAT_BUSY_POS] !== 1'b0 || rword[STAT_DONE_POS] !== 1'b1) && n < 8000);
    if (n >= 8000) timeout();
  endtask
  task automatic rd_feat(input logic [1:0] tgt, input logic [7:0] lo, input logic [7:0] cnt,
                         input efr_byte_t b);
    run(KIND_READ, 8'(tgt), lo, cnt);
    expect_rd(OFS_STATUS, 33'h0_0000_FF03, {17'h0_0000, b, 8'h02});
  endtask
  task automatic probe(input logic [1:0] kind, input logic ack);
    run(kind, 8'(TGT_IDP), 8'h00, 8'h01);
    expect_rd(OFS_STATUS, 33'h0_0000_0007, {30'h0000_0000, ack, 2'b10});
  endtask
  // Device-side loads: one page byte or one feature register
  task automatic load(input logic pg, input logic sel, input efr_byte_t a, input efr_byte_t d);
    @(posedge clk_sys);
    idp_we   <= pg;
    cfg_we   <= !pg;
    cfg_sel  <= sel;
    idp_addr <= a;
    {idp_data, cfg_data} <= {d, d};
    @(posedge clk_sys);
    {idp_we, cfg_we} <= 2'b00;
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, chk_en, write_busy, page_locked, cs_cur} = 8'h00;
    {cfg_we, cfg_sel, idp_we, paddr, pwdata, cfg_data, idp_addr, idp_data} = 67'h0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    void'($urandom(32'h9a52fc77));
    // Controller defaults and an unmapped offset
    expect_rd(OFS_COUNT, 33'h0_0000_00FF, 33'h0_0000_0001);
    expect_rd(8'h10, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
    rd_feat(TGT_IDP, 8'($urandom), 8'h01, IDP_ERASED);
    rd_feat(TGT_CADR, 8'h00, 8'h01, CADR_RESET);
    rd_feat(TGT_PROT, 8'h00, 8'h01, PROT_RESET);
    // Page stream crossing the top offset ends on offset zero
    pg0 = 8'($urandom);
    pgf = 8'($urandom);
    load(1'b1, 1'b0, 8'h00, pg0);
    load(1'b1, 1'b0, 8'hFF, pgf);
    rd_feat(TGT_IDP, 8'hFF, 8'h01, pgf);
    rd_feat(TGT_IDP, 8'hFE, 8'h03, pg0);
    rd_feat(TGT_TYPE, 8'h00, 8'h03, TYPE_ID_V);
    // Chip-select probes before and after the stored bit changes
    cadr = 8'($urandom) | 8'h02;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) load(1'b0, 1'b0, 8'h00, cadr);
      cs_cur = i[0];
      probe(KIND_PROBE, i[0] == (i >= 2));
    end
    rd_feat(TGT_CADR, 8'h00, 8'h02, cadr);
    prot = 8'($urandom);
    load(1'b0, 1'b1, 8'h00, prot);
    rd_feat(TGT_PROT, 8'h00, 8'h04, prot);
    // Lock-status probe both ways, then a normal read still works
    for (int i = 0; i < 2; i++) begin
      page_locked <= i[0];
      probe(KIND_LOCK, !i[0]);
    end
    page_locked <= 1'b0;
    rd_feat(TGT_IDP, 8'h00, 8'h01, pg0);
    // Internal write cycle: every select goes unanswered
    write_busy <= 1'b1;
    for (int t = 1; t < 4; t++) begin
      run(KIND_READ, 8'(t), 8'h00, 8'h01);
      expect_rd(OFS_STATUS, 33'h0_0000_0007, 33'h0_0000_0002);
    end
    probe(KIND_PROBE, 1'b0);
    write_busy <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
